//--- inc/boisx_regs.vh
// constants for the branch/or/increment/shift execution datapath
// assumes inclusion by the datapath module only
`ifndef BOISX_REGS_VH
`define BOISX_REGS_VH

// operation select codes
`define BOISX_OP_NONE   3'h0
`define BOISX_OP_BRANCH 3'h1
`define BOISX_OP_ORLIT  3'h2
`define BOISX_OP_ORREG  3'h3
`define BOISX_OP_INC    3'h4
`define BOISX_OP_SHL    3'h5
`define BOISX_OP_SHR    3'h6

// latch register field feeding the upper program counter bits
`define BOISX_LATCH_HI  4
`define BOISX_LATCH_LO  3

// reset values
`define BOISX_ACC_RST   8'h00
`define BOISX_PC_RST    13'h0000

// cycle counts
`define BOISX_BRANCH_CYC 2'h2
`define BOISX_SINGLE_CYC 2'h1

`endif

//--- tb/boisx_exec_checker.sv
// assertions for boisx_exec
// bound into every boisx_exec, sees its ports only
`timescale 1ns/100ps
module boisx_exec_checker (
  input logic        core_clk, nrst, op_valid, dest_sel, busy,
  input logic        pc_load, zero_flag, carry_flag, file_wr_en, op_done,
  input logic [2:0]  op_sel,
  input logic [10:0] branch_imm,
  input logic [7:0]  file_rd_data, literal_in, pc_upper_latch, acc_out, file_wr_data,
  input logic [12:0] pc_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire go = op_valid && !busy;
  a_branch_load: assert property (
    go && op_sel==3'h1 |=> pc_load && pc_out=={$past(pc_upper_latch[4:3]),$past(branch_imm)})
    else $error("branch target");
  a_branch_flags: assert property (
    go && op_sel==3'h1 |=> !op_done && busy ##0 $stable({zero_flag,carry_flag})[*2] ##0 op_done)
    else $error("branch timing");
  a_or_literal: assert property (
    go && op_sel==3'h2 |=> acc_out==($past(acc_out)|$past(literal_in))
    && zero_flag==!acc_out && $stable(carry_flag) && op_done) else $error("or literal");
  a_inc_file: assert property (
    go && op_sel==3'h4 && dest_sel |=> file_wr_en && file_wr_data==$past(file_rd_data)+8'h01)
    else $error("increment");
  a_dest_acc: assert property (
    go && op_sel>3'h2 && op_sel<3'h7 && !dest_sel |=> !file_wr_en && op_done)
    else $error("destination");
  a_or_reg: assert property (
    go && op_sel==3'h3 |=> $stable(carry_flag) && file_wr_en==$past(dest_sel)
    && (file_wr_en?file_wr_data:acc_out)==($past(acc_out)|$past(file_rd_data)))
    else $error("or register");
  a_shl_carry: assert property (
    go && op_sel==3'h5 |=> carry_flag==$past(file_rd_data[7])) else $error("left carry");
  a_shr_carry: assert property (
    go && op_sel==3'h6 |=> carry_flag==$past(file_rd_data[0])) else $error("right carry");
endmodule // boisx_exec_checker
bind boisx_exec boisx_exec_checker chk (.*);

//--- tb/tb_boisx_exec.sv
// self-checking bench for boisx_exec
// drives random ops, checks each result at op_done
`timescale 1ns/100ps
module tb_boisx_exec;
  logic core_clk=0, nrst=0, op_valid=0, dest_sel=0;
  logic [2:0] op_sel=0;
  logic [10:0] branch_imm=0;
  logic [6:0] file_addr=0, file_wr_addr;
  logic [7:0] literal_in=0, file_rd_data=0, pc_upper_latch=0, acc_out, file_wr_data, a=0, r;
  logic [12:0] pc_out;
  logic pc_load, zero_flag, carry_flag, file_wr_en, busy, op_done;
  logic [16:0] q[$], e;
  logic [8:0] qz[$], z;
  int miscompares=0, n_checks=0, cyc=0;
  always #5 core_clk = ~core_clk;
  boisx_exec DUT (.*);
  task chk(input logic [16:0] s, x);
    n_checks++;
    if (s !== x) begin
      miscompares++;
      $display("BAD result exp %h seen %h", x, s);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task op(input logic [2:0] s, input logic [7:0] f);
    @(posedge core_clk) #1;
    {op_valid, op_sel, file_rd_data, dest_sel} = {1'b1, s, f, 1'($urandom)};
    {literal_in, branch_imm, pc_upper_latch, file_addr} = 34'({$urandom, $urandom});
    case (s)
      1: q.push_back({4'h8, pc_upper_latch[4:3], branch_imm});
      2: r = a | literal_in;
      3: r = a | f;
      4: r = f + 8'h01;
      5: r = {f[6:0], 1'b0};
      6: r = {1'b0, f[7:1]};
    endcase
    if (s > 3'h1 && s < 3'h7) begin
      q.push_back({9'h0, r});
      qz.push_back({r == 8'h00, s != 3'h2 && dest_sel, file_addr});
      if (s == 3'h2 || !dest_sel) a = r;
    end
    if (s == 3'h1) begin
      @(posedge core_clk) #1;
      op_sel = 3'h4; // dropped while busy
    end
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      miscompares++;
      results;
    end
    if (op_done) begin
      e = q.size() ? q.pop_front() : 17'h1FFFF;
      chk({e[16], 3'h0, e[16] ? pc_out : {5'h0, file_wr_en ? file_wr_data : acc_out}}, e);
      if (!e[16] && qz.size()) begin
        z = qz.pop_front();
        chk(17'(zero_flag), 17'(z[8]));
        chk(17'(file_wr_en), 17'(z[7]));
        if (z[7]) chk(17'(file_wr_addr), 17'(z[6:0]));
      end
    end
  end
  initial begin
    void'($urandom(32'hC3D32685));
    repeat (8) @(posedge core_clk);
    #1 nrst = 1;
    op(3'h4, 8'hFF);
    op(3'h5, 8'h80);
    op(3'h6, 8'h01);
    repeat (300) op(3'($urandom), 8'($urandom));
    @(posedge core_clk) #1;
    op_valid = 0;
    repeat (4) @(posedge core_clk);
    chk(17'(q.size()), 17'h0);
    chk(17'(qz.size()), 17'h0);
    results;
  end
endmodule // tb_boisx_exec

//--- verilog/boisx_exec.v
// execution datapath for branch, or, increment and logical shifts
// assumes a decoder on core_clk presents one operation per op_valid pulse
// and a register file that supplies file_rd_data for file_addr combinationally
//
// Operation
// RQ1: branch loads eleven-bit immediate into pc low
// RQ2: branch fills pc 12:11 from latch 4:3
// RQ3: branch takes two cycles, flags untouched
// RQ4: or literal into accumulator, update zero
// RQ5: increment addressed file register, update zero
// RQ6: destination bit zero accumulator, one file
// RQ7: or accumulator with register, update zero
// RQ8: left shift, bit zero forced low
// RQ9: left shift carry from bit seven, zero
// RQ10: right shift, bit seven forced low
// RQ11: right shift carry from bit zero, zero
// RQ12: zero flag set when result is zero
// RQ13: others single cycle, or/inc keep carry
`timescale 1ns/100ps
`include "boisx_regs.vh"

module boisx_exec #(
  parameter DATA_W = 8,
  parameter ADDR_W = 7,
  parameter IMM_W  = 11,
  parameter PC_W   = 13
) (
  input  wire              core_clk,
  input  wire              nrst,
  input  wire              op_valid,
  input  wire [2:0]        op_sel,
  input  wire [IMM_W-1:0]  branch_imm,
  input  wire [DATA_W-1:0] literal_in,
  input  wire [ADDR_W-1:0] file_addr,
  input  wire              dest_sel,
  input  wire [DATA_W-1:0] file_rd_data,
  input  wire [DATA_W-1:0] pc_upper_latch,
  output reg  [PC_W-1:0]   pc_out,
  output reg               pc_load,
  output reg  [DATA_W-1:0] acc_out,
  output reg               zero_flag,
  output reg               carry_flag,
  output reg               file_wr_en,
  output reg  [ADDR_W-1:0] file_wr_addr,
  output reg  [DATA_W-1:0] file_wr_data,
  output reg               busy,
  output reg               op_done
);

  // one-hot states
  localparam ST_IDLE   = 2'b01;
  localparam ST_BRANCH = 2'b10;

  reg [1:0]        state_reg;
  reg [1:0]        state_next;
  reg [DATA_W-1:0] result;
  reg              wr_zero;
  reg              wr_carry;
  reg              carry_val;
  reg              to_file;
  reg              is_branch;
  reg              single_done;

  wire accept;
  assign accept = op_valid & ~busy;

  // combinational result and flag selection
  always @* begin
    result      = {DATA_W{1'b0}};
    wr_zero     = 1'b0;
    wr_carry    = 1'b0;
    carry_val   = carry_flag;
    to_file     = 1'b0;
    is_branch   = 1'b0;
    single_done = 1'b0;
    case (op_sel)
      `BOISX_OP_BRANCH: begin
        is_branch = 1'b1; // RQ3
      end
      `BOISX_OP_ORLIT: begin
        result      = acc_out | literal_in; // RQ4
        wr_zero     = 1'b1;
        single_done = 1'b1;
      end
      `BOISX_OP_ORREG: begin
        result      = acc_out | file_rd_data; // RQ7
        wr_zero     = 1'b1;
        to_file     = dest_sel; // RQ6
        single_done = 1'b1;
      end
      `BOISX_OP_INC: begin
        result      = file_rd_data + {{(DATA_W-1){1'b0}}, 1'b1}; // RQ5
        wr_zero     = 1'b1;
        to_file     = dest_sel; // RQ6
        single_done = 1'b1; // RQ13
      end
      `BOISX_OP_SHL: begin
        result      = {file_rd_data[DATA_W-2:0], 1'b0}; // RQ8
        wr_zero     = 1'b1;
        wr_carry    = 1'b1;
        carry_val   = file_rd_data[DATA_W-1]; // RQ9
        to_file     = dest_sel; // RQ6
        single_done = 1'b1;
      end
      `BOISX_OP_SHR: begin
        result      = {1'b0, file_rd_data[DATA_W-1:1]}; // RQ10
        wr_zero     = 1'b1;
        wr_carry    = 1'b1;
        carry_val   = file_rd_data[0]; // RQ11
        to_file     = dest_sel; // RQ6
        single_done = 1'b1;
      end
      default: begin
        single_done = 1'b0;
      end
    endcase
  end

  // branch sequencing
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept && is_branch) begin
          state_next = ST_BRANCH; // RQ3
        end
      end
      ST_BRANCH: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= ST_IDLE;
      pc_out       <= `BOISX_PC_RST;
      pc_load      <= 1'b0;
      acc_out      <= `BOISX_ACC_RST;
      zero_flag    <= 1'b0;
      carry_flag   <= 1'b0;
      file_wr_en   <= 1'b0;
      file_wr_addr <= {ADDR_W{1'b0}};
      file_wr_data <= {DATA_W{1'b0}};
      busy         <= 1'b0;
      op_done      <= 1'b0;
    end else begin
      state_reg  <= state_next;
      pc_load    <= 1'b0;
      file_wr_en <= 1'b0;
      op_done    <= 1'b0;
      busy       <= 1'b0;
      if (state_reg == ST_BRANCH) begin
        op_done <= 1'b1; // RQ3
      end else if (accept && is_branch) begin
        pc_out  <= {pc_upper_latch[`BOISX_LATCH_HI:`BOISX_LATCH_LO], branch_imm}; // RQ1 RQ2
        pc_load <= 1'b1;
        busy    <= 1'b1;
      end else if (accept && single_done) begin
        op_done <= 1'b1; // RQ13
        if (to_file) begin
          file_wr_en   <= 1'b1; // RQ6
          file_wr_addr <= file_addr;
          file_wr_data <= result;
        end else begin
          acc_out <= result; // RQ6
        end
        if (wr_zero) begin
          zero_flag <= (result == {DATA_W{1'b0}}); // RQ12
        end
        if (wr_carry) begin
          carry_flag <= carry_val; // RQ9 RQ11
        end
      end
    end
  end

endmodule // boisx_exec
